// ===== rtl/epl_loader.v
// Autoload of per-port configuration images from serial EEPROM words, with an AXI4-Lite view
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "epl_map.vh"

// How it works
// - Word 0Ch bit9 to CCh bit21, ports 1-5
// - Word 0Ch bit10 freezes ordering, 8Ch bit6
// - Word 0Ch bit11 to 8Ch bit0
// - Word 0Ch bit12 to CCh bit19
// - Word 0Ch bit13 to 8Ch bit1
// - Word 0Ch bit14 to E4h bit12
// - Word 0Ch bit15 to 8Ch bit3
// - Word 0Eh bits14:0 to 94h margin levels
// - Word 0Eh bit15 to E4h bit18
// - Word 10h bits14:0 to 74h bits30:16
// - Word 10h bit15 to 8Ch bit31
// - Word 12h bits14:0 to 78h bits30:16
// - Word 12h bit15 to 3Ch bit8, ports 1-5
// - Word 14h bits6:0 to 7Ch bits6:0
// - Word 14h bits11:7 to 90h bits19:15
// - Word 14h bits12-14 to 8Ch bits 2,7,12
// - Words 16h,18h form 84h vendor word
// - Word 1Ah and 1Ch low byte to 88h
// - Word 1Eh upper byte to 98h bits23:16
// - Word 1Eh bits5:0 to 90h bits25:20
module epl_loader #(
    parameter NUM_PORTS = 6
) (
    input wire clk,
    input wire reset,
    input wire ee_word_valid,
    input wire [7:0] ee_word_addr,
    input wire [15:0] ee_word_data,
    input wire ee_load_done,
    output reg cfg_ready,
    output wire [NUM_PORTS*32-1:0] img_intpin,
    output wire [NUM_PORTS*32-1:0] img_phy0,
    output wire [NUM_PORTS*32-1:0] img_phy1,
    output wire [NUM_PORTS*32-1:0] img_phy2,
    output wire [NUM_PORTS*32-1:0] img_vphy_a,
    output wire [NUM_PORTS*32-1:0] img_vphy_b,
    output wire [NUM_PORTS*32-1:0] img_tlctl,
    output wire [NUM_PORTS*32-1:0] img_phy3,
    output wire [NUM_PORTS*32-1:0] img_margin,
    output wire [NUM_PORTS*32-1:0] img_bufctl,
    output wire [NUM_PORTS*32-1:0] img_linkcap,
    output wire [NUM_PORTS*32-1:0] img_devcap2,
    input wire [15:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [15:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ****************************************
    // Control and status
    // ****************************************
    reg load_enable;
    reg restart;
    reg [7:0] word_count;
    reg [7:0] last_word_addr;
    wire word_take;
    wire word_mapped;

    // Words are taken only while the images are not yet released
    assign word_take = ee_word_valid && load_enable && !cfg_ready && !restart;
    assign word_mapped = (ee_word_addr >= `EPL_WA_CAPS) && (ee_word_addr <= `EPL_WA_REFCLK) &&
        !ee_word_addr[0];

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    reg aw_hold;
    reg w_hold;
    reg [15:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg next_aw_hold;
    reg next_w_hold;
    reg next_bvalid;
    reg do_write;

    always @*
    begin
        next_aw_hold = aw_hold;
        next_w_hold = w_hold;
        next_bvalid = s_axi_bvalid;
        do_write = 1'b0;
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
            next_aw_hold = 1'b1;
        if (s_axi_wvalid && s_axi_wready)
            next_w_hold = 1'b1;
        if (aw_hold && w_hold && !s_axi_bvalid)
        begin
            do_write = 1'b1;
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
        end
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 16'h0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EPL_RESP_OKAY;
            load_enable <= `EPL_RST_ENABLE;
            restart <= 1'b0;
        end
        else
        begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            s_axi_bvalid <= next_bvalid;
            s_axi_awready <= !next_aw_hold && !next_bvalid;
            s_axi_wready <= !next_w_hold && !next_bvalid;
            restart <= 1'b0;
            if (s_axi_awvalid && s_axi_awready)
                aw_addr <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                if (aw_addr[15:2] == `EPL_ADDR_CTRL >> 2)
                begin
                    s_axi_bresp <= `EPL_RESP_OKAY;
                    if (w_strb[0])
                    begin
                        load_enable <= w_data[`EPL_CTRL_ENABLE];
                        restart <= w_data[`EPL_CTRL_RESTART];
                    end
                end
                else if (aw_addr[15:2] == `EPL_ADDR_STATUS >> 2)
                    s_axi_bresp <= `EPL_RESP_OKAY;
                else
                    s_axi_bresp <= `EPL_RESP_SLVERR;
            end
        end
    end

    // ****************************************
    // Load progress
    // ****************************************
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cfg_ready <= 1'b0;
            word_count <= 8'h00;
            last_word_addr <= 8'h00;
        end
        else
        begin
            if (restart)
            begin
                cfg_ready <= 1'b0;
                word_count <= 8'h00;
            end
            if (word_take && word_mapped)
            begin
                word_count <= word_count + 8'h01;
                last_word_addr <= ee_word_addr;
            end
            if (ee_load_done && load_enable)
                cfg_ready <= 1'b1;
        end
    end

    // ****************************************
    // Per-port images
    // ****************************************
    localparam [383:0] RESET_IMAGE = {`EPL_RST_INTPIN, `EPL_RST_PHY0, `EPL_RST_PHY1, `EPL_RST_PHY2,
        `EPL_RST_VPHY_A, `EPL_RST_VPHY_B, `EPL_RST_TLCTL, `EPL_RST_PHY3, `EPL_RST_MARGIN, `EPL_RST_BUFCTL,
        `EPL_RST_LINKCAP, `EPL_RST_DEVCAP2};
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1)
        begin : g_port
            localparam DOWNSTREAM = (p != 0);
            reg [31:0] r_intpin;
            reg [31:0] r_phy0;
            reg [31:0] r_phy1;
            reg [31:0] r_phy2;
            reg [31:0] r_vphy_a;
            reg [31:0] r_vphy_b;
            reg [31:0] r_tlctl;
            reg [31:0] r_phy3;
            reg [31:0] r_margin;
            reg [31:0] r_bufctl;
            reg [31:0] r_linkcap;
            reg [31:0] r_devcap2;

            always @(posedge clk or posedge reset)
            begin
                if (reset)
                    {r_intpin, r_phy0, r_phy1, r_phy2, r_vphy_a, r_vphy_b, r_tlctl, r_phy3, r_margin, r_bufctl,
                        r_linkcap, r_devcap2} <= RESET_IMAGE;
                else if (restart)
                    {r_intpin, r_phy0, r_phy1, r_phy2, r_vphy_a, r_vphy_b, r_tlctl, r_phy3, r_margin, r_bufctl,
                        r_linkcap, r_devcap2} <= RESET_IMAGE;
                else if (word_take)
                begin
                    case (ee_word_addr)
                        `EPL_WA_CAPS:
                        begin
                            if (DOWNSTREAM)
                                r_linkcap[21] <= ee_word_data[9];
                            r_tlctl[6] <= ee_word_data[10];
                            r_tlctl[0] <= ee_word_data[11];
                            r_linkcap[19] <= ee_word_data[12];
                            r_tlctl[1] <= ee_word_data[13];
                            r_devcap2[12] <= ee_word_data[14];
                            r_tlctl[3] <= ee_word_data[15];
                        end
                        `EPL_WA_MARGIN:
                        begin
                            r_margin[14:0] <= ee_word_data[14:0];
                            r_devcap2[18] <= ee_word_data[15];
                        end
                        `EPL_WA_DRIVE:
                        begin
                            r_phy0[30:16] <= ee_word_data[14:0];
                            r_tlctl[31] <= ee_word_data[15];
                        end
                        `EPL_WA_EMPH:
                        begin
                            r_phy1[30:16] <= ee_word_data[14:0];
                            if (DOWNSTREAM)
                                r_intpin[8] <= ee_word_data[15];
                        end
                        `EPL_WA_PHY2:
                        begin
                            r_phy2[6:0] <= ee_word_data[6:0];
                            r_phy3[19:15] <= ee_word_data[11:7];
                            r_tlctl[2] <= ee_word_data[12];
                            r_tlctl[7] <= ee_word_data[13];
                            r_tlctl[12] <= ee_word_data[14];
                        end
                        `EPL_WA_VPHY_A_LO: r_vphy_a[15:0] <= ee_word_data;
                        `EPL_WA_VPHY_A_HI: r_vphy_a[31:16] <= ee_word_data;
                        `EPL_WA_VPHY_B_LO: r_vphy_b[15:0] <= ee_word_data;
                        `EPL_WA_VPHY_B_HI: r_vphy_b[23:16] <= ee_word_data[7:0];
                        `EPL_WA_REFCLK:
                        begin
                            r_bufctl[23:16] <= ee_word_data[15:8];
                            r_phy3[25:20] <= ee_word_data[5:0];
                        end
                        default: ;
                    endcase
                end
            end

            assign img_intpin[p*32 +: 32] = r_intpin;
            assign img_phy0[p*32 +: 32] = r_phy0;
            assign img_phy1[p*32 +: 32] = r_phy1;
            assign img_phy2[p*32 +: 32] = r_phy2;
            assign img_vphy_a[p*32 +: 32] = r_vphy_a;
            assign img_vphy_b[p*32 +: 32] = r_vphy_b;
            assign img_tlctl[p*32 +: 32] = r_tlctl;
            assign img_phy3[p*32 +: 32] = r_phy3;
            assign img_margin[p*32 +: 32] = r_margin;
            assign img_bufctl[p*32 +: 32] = r_bufctl;
            assign img_linkcap[p*32 +: 32] = r_linkcap;
            assign img_devcap2[p*32 +: 32] = r_devcap2;
        end
    endgenerate

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    reg [31:0] rd_word;
    reg rd_ok;
    wire [2:0] rd_port;
    wire [7:0] rd_off;

    assign rd_port = s_axi_araddr[10:8];
    assign rd_off = s_axi_araddr[7:0];

    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
        if (s_axi_araddr[15:2] == `EPL_ADDR_CTRL >> 2)
        begin
            rd_ok = 1'b1;
            rd_word = {31'h0000_0000, load_enable};
        end
        else if (s_axi_araddr[15:2] == `EPL_ADDR_STATUS >> 2)
        begin
            rd_ok = 1'b1;
            rd_word = {8'h00, last_word_addr, word_count, 7'h00, cfg_ready};
        end
        else if (s_axi_araddr[15:11] == `EPL_ADDR_IMG_BASE >> 11 && rd_port < NUM_PORTS)
        begin
            rd_ok = 1'b1;
            case (rd_off)
                `EPL_CFG_INTPIN: rd_word = img_intpin[rd_port*32 +: 32];
                `EPL_CFG_PHY0: rd_word = img_phy0[rd_port*32 +: 32];
                `EPL_CFG_PHY1: rd_word = img_phy1[rd_port*32 +: 32];
                `EPL_CFG_PHY2: rd_word = img_phy2[rd_port*32 +: 32];
                `EPL_CFG_VPHY_A: rd_word = img_vphy_a[rd_port*32 +: 32];
                `EPL_CFG_VPHY_B: rd_word = img_vphy_b[rd_port*32 +: 32];
                `EPL_CFG_TLCTL: rd_word = img_tlctl[rd_port*32 +: 32];
                `EPL_CFG_PHY3: rd_word = img_phy3[rd_port*32 +: 32];
                `EPL_CFG_MARGIN: rd_word = img_margin[rd_port*32 +: 32];
                `EPL_CFG_BUFCTL: rd_word = img_bufctl[rd_port*32 +: 32];
                `EPL_CFG_LINKCAP: rd_word = img_linkcap[rd_port*32 +: 32];
                `EPL_CFG_DEVCAP2: rd_word = img_devcap2[rd_port*32 +: 32];
                default: rd_ok = 1'b0;
            endcase
        end
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `EPL_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `EPL_RESP_OKAY : `EPL_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        else
            s_axi_arready <= !s_axi_rvalid;
    end

endmodule

// ===== rtl/epl_map.vh
// Constants for the configuration autoload block: word addresses, offsets, fields, resets
`ifndef EPL_MAP_VH
`define EPL_MAP_VH

// ****************************************
// Autoload word addresses (byte address of each 16-bit word)
// ****************************************
`define EPL_WA_CAPS 8'h0c
`define EPL_WA_MARGIN 8'h0e
`define EPL_WA_DRIVE 8'h10
`define EPL_WA_EMPH 8'h12
`define EPL_WA_PHY2 8'h14
`define EPL_WA_VPHY_A_LO 8'h16
`define EPL_WA_VPHY_A_HI 8'h18
`define EPL_WA_VPHY_B_LO 8'h1a
`define EPL_WA_VPHY_B_HI 8'h1c
`define EPL_WA_REFCLK 8'h1e

// ****************************************
// Per-port configuration offsets
// ****************************************
`define EPL_CFG_INTPIN 8'h3c
`define EPL_CFG_PHY0 8'h74
`define EPL_CFG_PHY1 8'h78
`define EPL_CFG_PHY2 8'h7c
`define EPL_CFG_VPHY_A 8'h84
`define EPL_CFG_VPHY_B 8'h88
`define EPL_CFG_TLCTL 8'h8c
`define EPL_CFG_PHY3 8'h90
`define EPL_CFG_MARGIN 8'h94
`define EPL_CFG_BUFCTL 8'h98
`define EPL_CFG_LINKCAP 8'hcc
`define EPL_CFG_DEVCAP2 8'he4

// ****************************************
// Reset values of the per-port images
// ****************************************
`define EPL_RST_INTPIN 32'h0000_0000
`define EPL_RST_PHY0 32'h0000_0000
`define EPL_RST_PHY1 32'h0000_0000
`define EPL_RST_PHY2 32'h0000_0000
`define EPL_RST_VPHY_A 32'h0000_0000
`define EPL_RST_VPHY_B 32'h0000_0000
`define EPL_RST_TLCTL 32'h0000_0000
`define EPL_RST_PHY3 32'h0000_0000
`define EPL_RST_MARGIN 32'h0000_0000
`define EPL_RST_BUFCTL 32'h0000_0000
`define EPL_RST_LINKCAP 32'h0000_0000
`define EPL_RST_DEVCAP2 32'h0000_0000

// ****************************************
// Software register map (byte addresses)
// ****************************************
`define EPL_ADDR_CTRL 16'h0000
`define EPL_ADDR_STATUS 16'h0004
`define EPL_ADDR_IMG_BASE 16'h1000
`define EPL_CTRL_ENABLE 0
`define EPL_CTRL_RESTART 1
`define EPL_RST_ENABLE 1'b1
`define EPL_RESP_OKAY 2'b00
`define EPL_RESP_SLVERR 2'b10

`endif

// ===== sim/epl_eeprom_model.sv
// Serial EEPROM model that streams autoload words
`timescale 1ns/100ps
module epl_eeprom_model (
    input wire clk,
    output reg ee_word_valid = 1'b0,
    output reg [7:0] ee_word_addr = 8'h00,
    output reg [15:0] ee_word_data = 16'h0000,
    output reg ee_load_done = 1'b0
);
    // Present one word, valid left high for back-to-back use
    task send_word(input [7:0] a, input [15:0] d);
        begin
            ee_word_valid <= 1'b1;
            ee_word_addr <= a;
            ee_word_data <= d;
            @(posedge clk);
        end
    endtask
    // Released lines show the inverse of the last value
    task idle(input integer n);
        begin
            ee_word_valid <= 1'b0;
            ee_word_addr <= ~ee_word_addr;
            ee_word_data <= ~ee_word_data;
            repeat (n) @(posedge clk);
        end
    endtask
    task finish;
        begin
            ee_load_done <= 1'b1;
            @(posedge clk);
            ee_load_done <= 1'b0;
            @(posedge clk);
        end
    endtask
endmodule

// ===== sim/epl_loader_chk.sv
// Port assertions for the configuration autoload block
`timescale 1ns/100ps
module epl_loader_chk #(
    parameter NUM_PORTS = 6
) (
    input wire clk,
    input wire reset,
    input wire ee_word_valid,
    input wire [7:0] ee_word_addr,
    input wire [15:0] ee_word_data,
    input wire ee_load_done,
    input wire cfg_ready,
    input wire [NUM_PORTS*32-1:0] img_intpin,
    input wire [NUM_PORTS*32-1:0] img_phy0,
    input wire [NUM_PORTS*32-1:0] img_phy1,
    input wire [NUM_PORTS*32-1:0] img_phy2,
    input wire [NUM_PORTS*32-1:0] img_vphy_a,
    input wire [NUM_PORTS*32-1:0] img_tlctl,
    input wire [NUM_PORTS*32-1:0] img_margin,
    input wire [NUM_PORTS*32-1:0] img_linkcap,
    input wire [NUM_PORTS*32-1:0] img_devcap2,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire take = ee_word_valid && !cfg_ready;
    chk_caps_tl: assert property (take && ee_word_addr == 8'h0c |=> img_tlctl[0] == $past(ee_word_data[11])
        && img_tlctl[1] == $past(ee_word_data[13]) && img_tlctl[3] == $past(ee_word_data[15])
        && img_tlctl[6] == $past(ee_word_data[10])) else $error("caps word not copied to 8Ch");
    chk_caps_cap: assert property (take && ee_word_addr == 8'h0c |=> img_linkcap[19] == $past(ee_word_data[12])
        && img_linkcap[53] == $past(ee_word_data[9]) && img_devcap2[12] == $past(ee_word_data[14]))
        else $error("caps word not copied to capabilities");
    chk_port0_excl: assert property (img_linkcap[21] == 1'b0 && img_intpin[8] == 1'b0)
        else $error("port 0 got a ports 1-5 bit");
    chk_margin_copy: assert property (take && ee_word_addr == 8'h0e |=> img_margin[14:0] == $past(ee_word_data[14:0])
        && img_devcap2[18] == $past(ee_word_data[15])) else $error("margin word not copied");
    chk_drive_copy: assert property (take && ee_word_addr == 8'h10 |=> img_phy0[30:16] == $past(ee_word_data[14:0])
        && img_tlctl[31] == $past(ee_word_data[15])) else $error("drive word not copied");
    chk_emph_copy: assert property (take && ee_word_addr == 8'h12 |=> img_phy1[30:16] == $past(ee_word_data[14:0])
        && img_intpin[40] == $past(ee_word_data[15])) else $error("emphasis word not copied");
    chk_phy2_copy: assert property (take && ee_word_addr == 8'h14 |=> img_phy2[6:0] == $past(ee_word_data[6:0])
        && img_tlctl[2] == $past(ee_word_data[12]) && img_tlctl[7] == $past(ee_word_data[13])
        && img_tlctl[12] == $past(ee_word_data[14])) else $error("word 14h not copied");
    chk_vphy_high: assert property (take && ee_word_addr == 8'h18 |=> img_vphy_a[31:16] == $past(ee_word_data))
        else $error("word 18h not copied");
    chk_same_ports: assert property (img_tlctl[NUM_PORTS*32-1 -: 32] == img_tlctl[31:0]
        && img_margin[NUM_PORTS*32-1 -: 32] == img_margin[31:0]) else $error("ports differ");
    chk_ready_set: assert property (ee_load_done |=> cfg_ready) else $error("load done did not set ready");
    chk_images_frozen: assert property (cfg_ready ##1 cfg_ready |-> $stable(img_tlctl) && $stable(img_margin))
        else $error("image changed while ready");
    chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
    cover property (take && ee_word_addr == 8'h14);
    cover property ($rose(cfg_ready));
    cover property ($fell(cfg_ready));
endmodule
bind epl_loader epl_loader_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk(clk), .reset(reset), .ee_word_valid(ee_word_valid),
    .ee_word_addr(ee_word_addr), .ee_word_data(ee_word_data), .ee_load_done(ee_load_done), .cfg_ready(cfg_ready),
    .img_intpin(img_intpin), .img_phy0(img_phy0), .img_phy1(img_phy1), .img_phy2(img_phy2), .img_vphy_a(img_vphy_a),
    .img_tlctl(img_tlctl), .img_margin(img_margin), .img_linkcap(img_linkcap), .img_devcap2(img_devcap2),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ===== sim/tb_top.sv
// Testbench for the configuration autoload block
`timescale 1ns/100ps
`include "epl_map.vh"
module tb_top;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg [15:0] awaddr = 16'h0000;
    reg [15:0] araddr = 16'h0000;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, cfg_ready, ee_valid, ee_done;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] ee_addr;
    wire [15:0] ee_data;
    wire [191:0] img [0:11];
    reg [31:0] exp_img [0:11];
    reg [31:0] rd, r;
    reg [1:0] resp;
    reg [7:0] cnt, a;
    reg [15:0] d;
    integer fails = 0, n_compared = 0, seed, k, p, j, round;
    always #4 clk = ~clk;
    epl_eeprom_model u_ee (.clk(clk), .ee_word_valid(ee_valid), .ee_word_addr(ee_addr), .ee_word_data(ee_data),
        .ee_load_done(ee_done));
    epl_loader #(.NUM_PORTS(6)) u_dut (.clk(clk), .reset(reset), .ee_word_valid(ee_valid), .ee_word_addr(ee_addr),
        .ee_word_data(ee_data), .ee_load_done(ee_done), .cfg_ready(cfg_ready), .img_intpin(img[0]), .img_phy0(img[1]),
        .img_phy1(img[2]), .img_phy2(img[3]), .img_vphy_a(img[4]), .img_vphy_b(img[5]), .img_tlctl(img[6]),
        .img_phy3(img[7]), .img_margin(img[8]), .img_bufctl(img[9]), .img_linkcap(img[10]), .img_devcap2(img[11]),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task give_verdict;
        begin
            if (fails == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] want);
        begin
            n_compared = n_compared + 1;
            if (seen !== want)
            begin
                fails = fails + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    // ****************************************
    // Reference model of the images
    // ****************************************
    task apply(input [7:0] wa, input [15:0] wd);
        begin
            if (wa >= 8'h0c && wa <= 8'h1e && !wa[0])
                cnt = cnt + 8'h01;
            case (wa)
                8'h0c: {exp_img[6][3], exp_img[11][12], exp_img[6][1], exp_img[10][19], exp_img[6][0], exp_img[6][6],
                    exp_img[10][21]} = wd[15:9];
                8'h0e: {exp_img[11][18], exp_img[8][14:0]} = wd;
                8'h10: {exp_img[6][31], exp_img[1][30:16]} = wd;
                8'h12: {exp_img[0][8], exp_img[2][30:16]} = wd;
                8'h14: {exp_img[6][12], exp_img[6][7], exp_img[6][2], exp_img[7][19:15], exp_img[3][6:0]} = wd[14:0];
                8'h16: exp_img[4][15:0] = wd;
                8'h18: exp_img[4][31:16] = wd;
                8'h1a: exp_img[5][15:0] = wd;
                8'h1c: exp_img[5][23:16] = wd[7:0];
                8'h1e: {exp_img[9][23:16], exp_img[7][25:20]} = {wd[15:8], wd[5:0]};
                default: ;
            endcase
        end
    endtask
    function [31:0] expv(input integer ki, input integer pi);
        begin
            expv = exp_img[ki];
            if (pi == 0 && ki == 10)
                expv[21] = 1'b0;
            if (pi == 0 && ki == 0)
                expv[8] = 1'b0;
        end
    endfunction
    localparam [95:0] CFG_OFFSETS = 96'he4cc9894908c88847c78743c;
    task check_all;
        for (k = 0; k < 12; k = k + 1)
            for (p = 0; p < 6; p = p + 1)
                check(img[k][p*32 +: 32], expv(k, p));
    endtask
    // ****************************************
    // Bus master tasks
    // ****************************************
    task axi_write(input [15:0] ad, input [31:0] wd, output [1:0] rs);
        integer i;
        reg aw_p, w_p, done;
        begin
            @(posedge clk);
            awaddr <= ad;
            wdata <= wd;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            {aw_p, w_p, done} = 3'b110;
            rs = 2'b11;
            for (i = 0; i < 50 && !done; i = i + 1)
            begin
                @(posedge clk);
                if (bvalid)
                begin
                    {rs, done} = {bresp, 1'b1};
                    bready <= 1'b0;
                end
                if (aw_p && awready)
                begin
                    aw_p = 1'b0;
                    awvalid <= 1'b0;
                end
                if (w_p && wready)
                begin
                    w_p = 1'b0;
                    wvalid <= 1'b0;
                end
            end
            fails = fails + !done;
            if (!done)
                give_verdict;
        end
    endtask
    task axi_read(input [15:0] ad, output [31:0] dt, output [1:0] rs);
        integer i;
        reg done;
        begin
            @(posedge clk);
            araddr <= ad;
            arvalid <= 1'b1;
            rready <= 1'b1;
            {dt, rs, done} = {32'hffff_ffff, 2'b11, 1'b0};
            for (i = 0; i < 50 && !done; i = i + 1)
            begin
                @(posedge clk);
                if (rvalid)
                begin
                    {dt, rs, done} = {rdata, rresp, 1'b1};
                    rready <= 1'b0;
                end
                if (arvalid && arready)
                    arvalid <= 1'b0;
            end
            fails = fails + !done;
            if (!done)
                give_verdict;
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        fails = fails + 1;
        give_verdict;
    end
    initial
    begin
        seed = 82493;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        axi_read(`EPL_ADDR_CTRL, rd, resp);
        check(rd, 32'h1);
        for (round = 0; round < 2; round = round + 1)
        begin
            for (k = 0; k < 12; k = k + 1)
                exp_img[k] = 32'h0;
            cnt = 8'h00;
            check_all;
            check({31'h0, cfg_ready}, 32'h0);
            // Every word, then odd, unmapped and repeated addresses
            for (j = 0; j < 13; j = j + 1)
            begin
                a = (j < 10) ? 8'h0c + {j[6:0], 1'b0} : (j == 10) ? 8'h0d : (j == 11) ? 8'h20 : 8'h0c;
                r = $random(seed);
                d = r[15:0];
                u_ee.send_word(a, d);
                apply(a, d);
                if (r[16])
                    u_ee.idle(1);
            end
            u_ee.idle(1);
            u_ee.finish;
            check({31'h0, cfg_ready}, 32'h1);
            check_all;
            axi_read(`EPL_ADDR_STATUS, rd, resp);
            check(rd, {8'h00, 8'h0c, cnt, 8'h01});
            u_ee.send_word(8'h0e, ~d);
            u_ee.idle(1);
            check_all;
            p = round * 5;
            for (k = 0; k < 12; k = k + 1)
            begin
                axi_read({4'h1, p[3:0], CFG_OFFSETS[k*8 +: 8]}, rd, resp);
                check(rd, expv(k, p));
            end
            axi_read(16'h1004, rd, resp);
            check({rd[29:0], resp}, {30'h0, `EPL_RESP_SLVERR});
            axi_write(16'h1000, 32'h1, resp);
            check({30'h0, resp}, {30'h0, `EPL_RESP_SLVERR});
            axi_write(`EPL_ADDR_CTRL, 32'h3, resp);
            @(posedge clk);
            check({31'h0, cfg_ready}, 32'h0);
        end
        give_verdict;
    end
endmodule
